// *** flcse_map.svh ***
// constants of the flash command/status host controller
// assumes a 100 MHz clock; times are in ns, counts in cycles
`ifndef FLCSE_MAP_SVH
`define FLCSE_MAP_SVH

`define FL_CMD_READ_ARRAY 8'hFF
`define FL_CMD_IDENTIFY 8'h90
`define FL_CMD_READ_STATUS 8'h70
`define FL_CMD_CLEAR_STATUS 8'h50
`define FL_CMD_ERASE_SETUP 8'h20
`define FL_CMD_CONFIRM 8'hD0
`define FL_CMD_WRITE_SETUP 8'h40
`define FL_CMD_WRITE_ALT 8'h10
`define FL_CMD_SUSPEND 8'hB0
`define FL_NULL_DATA 16'hFFFF

`define FL_SR_READY 7
`define FL_SR_SUSP 6
`define FL_SR_ERASE 5
`define FL_SR_WRITE 4
`define FL_SR_VPP 3
`define FL_SR_RESET 8'h00

`define FL_CLK_NS 10
`define FL_ACC_NS 80
`define FL_WE_NS 50
`define FL_RST_NS 100
`define FL_ACC_CYC ((`FL_ACC_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_WE_CYC ((`FL_WE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_RST_CYC ((`FL_RST_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)

`endif

// *** flcse_pkg.sv ***
// types of the flash command/status host controller
// assumes flcse_map.svh for the numbers
package flcse_pkg;

typedef enum logic [3:0] {
    FLCSE_OP_READ = 4'h0,
    FLCSE_OP_IDENT = 4'h1,
    FLCSE_OP_STATUS = 4'h2,
    FLCSE_OP_CLEAR = 4'h3,
    FLCSE_OP_WRITE = 4'h4,
    FLCSE_OP_ERASE = 4'h5,
    FLCSE_OP_SUSPEND = 4'h6,
    FLCSE_OP_RESUME = 4'h7,
    FLCSE_OP_NULLW = 4'h8,
    FLCSE_OP_RESET = 4'h9
} flcse_op_t;

typedef enum logic [2:0] {
    FLCSE_ST_IDLE = 3'h0,
    FLCSE_ST_CMD = 3'h1,
    FLCSE_ST_DATA = 3'h2,
    FLCSE_ST_POLL = 3'h3,
    FLCSE_ST_RD = 3'h4,
    FLCSE_ST_RST = 3'h5
} flcse_state_t;

typedef enum logic [1:0] {
    FLCSE_MD_ARRAY = 2'h0,
    FLCSE_MD_IDENT = 2'h1,
    FLCSE_MD_STATUS = 2'h2,
    FLCSE_MD_OTHER = 2'h3
} flcse_mode_t;

typedef enum logic [1:0] {
    FLCSE_PH_IDLE = 2'h0,
    FLCSE_PH_LOW = 2'h1,
    FLCSE_PH_HIGH = 2'h2
} flcse_phase_t;

typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe_n;
    logic [19:0] addr;
    logic [15:0] dq;
} flcse_pins_t;

typedef struct packed {
    flcse_phase_t ph;
    logic [3:0] cnt;
    flcse_pins_t pins;
    logic [15:0] rdata;
    logic done;
} flcse_bus_t;

typedef struct packed {
    flcse_state_t st;
    flcse_op_t op;
    flcse_mode_t mode;
    logic [19:0] addr;
    logic [15:0] data;
    logic [7:0] status;
    logic [31:0] pcnt;
    logic [3:0] rcnt;
    logic rp_n;
    logic supply;
    logic wp;
    logic start;
    logic bwrite;
    logic [19:0] baddr;
    logic [15:0] bdata;
    logic done;
    logic refused;
    logic timeout;
    logic [15:0] rdata;
} flcse_host_t;

endpackage : flcse_pkg

// *** flcse_bus.sv ***
// one asynchronous bus cycle (command/data write or read) on the flash pins
// assumes the caller starts a cycle only after the previous one is done
`timescale 1ns/100ps
`default_nettype none
`include "flcse_map.svh"

module flcse_bus
    import flcse_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [19:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic [15:0] dq_in,
    output flcse_pins_t pins_out,
    output logic done_out,
    output logic [15:0] rdata_out
);

    flcse_bus_t s_ff;
    flcse_bus_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        unique case (s_ff.ph)
            FLCSE_PH_IDLE: begin
                if (start_in) begin
                    nxt_s.pins.ce_n = 1'b0;
                    nxt_s.pins.we_n = ~write_in;
                    nxt_s.pins.oe_n = write_in;
                    nxt_s.pins.dq_oe_n = ~write_in;
                    nxt_s.pins.addr = addr_in;
                    nxt_s.pins.dq = data_in;
                    nxt_s.cnt = write_in ? 4'(`FL_WE_CYC) : 4'(`FL_ACC_CYC);
                    nxt_s.ph = FLCSE_PH_LOW;
                end
            end
            FLCSE_PH_LOW: begin
                nxt_s.cnt = s_ff.cnt - 4'h1;
                if (s_ff.cnt == 4'h1) begin
                    // rising strobe latches the write; data held one more cycle
                    nxt_s.pins.ce_n = 1'b1;
                    nxt_s.pins.we_n = 1'b1;
                    nxt_s.pins.oe_n = 1'b1;
                    if (s_ff.pins.we_n) begin
                        nxt_s.rdata = dq_in;
                    end
                    nxt_s.ph = FLCSE_PH_HIGH;
                end
            end
            FLCSE_PH_HIGH: begin
                nxt_s.pins.dq_oe_n = 1'b1;
                nxt_s.done = 1'b1;
                nxt_s.ph = FLCSE_PH_IDLE;
            end
            default: begin
                nxt_s.ph = FLCSE_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_ff <= '{ph: FLCSE_PH_IDLE, cnt: 4'h0,
                      pins: '{1'b1, 1'b1, 1'b1, 1'b1, 20'h00000, 16'h0000},
                      rdata: 16'h0000, done: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pins_out = s_ff.pins;
    assign done_out = s_ff.done;
    assign rdata_out = s_ff.rdata;

    chk_strobe_data_driven: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (!s_ff.pins.we_n) |-> (!s_ff.pins.dq_oe_n && s_ff.pins.oe_n))
        else $error("write strobe low without driven data");

endmodule : flcse_bus
`default_nettype wire

// *** flcse_host.sv ***
// host controller that drives a boot-block flash through its pins
// assumes a user port that issues one operation at a time while busy is low
`timescale 1ns/100ps
`default_nettype none
`include "flcse_map.svh"

// Function
// - status output holds; host toggles output or chip enable to refresh it
// - device starts in array read; FFh returns to it from any mode
// - host programs with 40h only (never 10h), then address and data with supply on
// - started write only stops by reset; all-ones data cancels after setup
// - host erases with 20h then D0h at a block address, supply on
module flcse_host
    import flcse_pkg::*;
#(
    parameter int unsigned POLL_MAX = 1000000
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic req_in,
    input wire flcse_op_t op_in,
    input wire logic [19:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic boot_in,
    output logic busy_out,
    output logic done_out,
    output logic refused_out,
    output logic timeout_out,
    output logic [15:0] rdata_out,
    output logic [7:0] status_out,
    input wire logic [15:0] dq_in,
    output flcse_pins_t pins_out,
    output logic rp_n_out,
    output logic supply_out,
    output logic wp_out
);

    flcse_host_t s_ff;
    flcse_host_t nxt_s;
    logic bus_done;
    logic [15:0] bus_rdata;

    flcse_bus u_bus (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .start_in(s_ff.start),
        .write_in(s_ff.bwrite),
        .addr_in(s_ff.baddr),
        .data_in(s_ff.bdata),
        .dq_in(dq_in),
        .pins_out(pins_out),
        .done_out(bus_done),
        .rdata_out(bus_rdata)
    );

    always_comb begin
        nxt_s = s_ff;
        nxt_s.start = 1'b0;
        nxt_s.done = 1'b0;
        nxt_s.refused = 1'b0;
        nxt_s.timeout = 1'b0;
        unique case (s_ff.st)
            FLCSE_ST_IDLE: begin
                if (req_in) begin
                    nxt_s.op = op_in;
                    nxt_s.addr = addr_in;
                    nxt_s.data = data_in;
                    nxt_s.start = 1'b1;
                    nxt_s.bwrite = 1'b1;
                    nxt_s.baddr = 20'h00000;
                    nxt_s.st = FLCSE_ST_CMD;
                    unique case (op_in)
                        FLCSE_OP_READ: begin
                            if (s_ff.mode == FLCSE_MD_ARRAY) begin
                                nxt_s.bwrite = 1'b0;
                                nxt_s.baddr = addr_in;
                                nxt_s.st = FLCSE_ST_RD;
                            end else begin
                                nxt_s.bdata = {8'h00, `FL_CMD_READ_ARRAY};
                            end
                        end
                        FLCSE_OP_IDENT: nxt_s.bdata = {8'h00, `FL_CMD_IDENTIFY};
                        FLCSE_OP_STATUS: nxt_s.bdata = {8'h00, `FL_CMD_READ_STATUS};
                        FLCSE_OP_CLEAR: nxt_s.bdata = {8'h00, `FL_CMD_CLEAR_STATUS};
                        FLCSE_OP_SUSPEND: nxt_s.bdata = {8'h00, `FL_CMD_SUSPEND};
                        FLCSE_OP_RESUME: nxt_s.bdata = {8'h00, `FL_CMD_CONFIRM};
                        FLCSE_OP_NULLW: nxt_s.bdata = {8'h00, `FL_CMD_WRITE_SETUP};
                        FLCSE_OP_WRITE, FLCSE_OP_ERASE: begin
                            if (s_ff.status[`FL_SR_VPP]) begin
                                // device would refuse anyway; do not start
                                nxt_s.start = 1'b0;
                                nxt_s.refused = 1'b1;
                                nxt_s.done = 1'b1;
                                nxt_s.st = FLCSE_ST_IDLE;
                            end else begin
                                nxt_s.supply = 1'b1;
                                nxt_s.wp = boot_in;
                                nxt_s.bdata = (op_in == FLCSE_OP_WRITE) ?
                                    {8'h00, `FL_CMD_WRITE_SETUP} : {8'h00, `FL_CMD_ERASE_SETUP};
                            end
                        end
                        FLCSE_OP_RESET: begin
                            nxt_s.start = 1'b0;
                            nxt_s.rp_n = 1'b0;
                            nxt_s.rcnt = 4'(`FL_RST_CYC);
                            nxt_s.st = FLCSE_ST_RST;
                        end
                        default: begin
                            nxt_s.start = 1'b0;
                            nxt_s.refused = 1'b1;
                            nxt_s.done = 1'b1;
                            nxt_s.st = FLCSE_ST_IDLE;
                        end
                    endcase
                end
            end
            FLCSE_ST_CMD: begin
                if (bus_done) begin
                    nxt_s.start = 1'b1;
                    nxt_s.bwrite = 1'b0;
                    nxt_s.baddr = s_ff.addr;
                    nxt_s.st = FLCSE_ST_RD;
                    unique case (s_ff.op)
                        FLCSE_OP_READ: nxt_s.mode = FLCSE_MD_ARRAY;
                        FLCSE_OP_IDENT: nxt_s.mode = FLCSE_MD_IDENT;
                        FLCSE_OP_STATUS: nxt_s.mode = FLCSE_MD_STATUS;
                        FLCSE_OP_WRITE, FLCSE_OP_ERASE, FLCSE_OP_NULLW: begin
                            nxt_s.bwrite = 1'b1;
                            nxt_s.bdata = (s_ff.op == FLCSE_OP_WRITE) ? s_ff.data :
                                (s_ff.op == FLCSE_OP_ERASE) ? {8'h00, `FL_CMD_CONFIRM} :
                                `FL_NULL_DATA;
                            nxt_s.st = FLCSE_ST_DATA;
                        end
                        FLCSE_OP_SUSPEND: begin
                            nxt_s.mode = FLCSE_MD_STATUS;
                            nxt_s.pcnt = 32'h00000000;
                            nxt_s.st = FLCSE_ST_POLL;
                        end
                        FLCSE_OP_CLEAR: begin
                            nxt_s.start = 1'b0;
                            nxt_s.status[`FL_SR_ERASE:`FL_SR_VPP] = 3'h0;
                            nxt_s.mode = FLCSE_MD_OTHER;
                            nxt_s.done = 1'b1;
                            nxt_s.st = FLCSE_ST_IDLE;
                        end
                        default: begin
                            nxt_s.start = 1'b0;
                            nxt_s.mode = FLCSE_MD_STATUS;
                            nxt_s.done = 1'b1;
                            nxt_s.st = FLCSE_ST_IDLE;
                        end
                    endcase
                end
            end
            FLCSE_ST_DATA: begin
                if (bus_done) begin
                    if (s_ff.op == FLCSE_OP_NULLW) begin
                        nxt_s.mode = FLCSE_MD_OTHER;
                        nxt_s.done = 1'b1;
                        nxt_s.st = FLCSE_ST_IDLE;
                    end else begin
                        nxt_s.mode = FLCSE_MD_STATUS;
                        nxt_s.start = 1'b1;
                        nxt_s.bwrite = 1'b0;
                        nxt_s.pcnt = 32'h00000000;
                        nxt_s.st = FLCSE_ST_POLL;
                    end
                end
            end
            FLCSE_ST_POLL: begin
                if (bus_done) begin
                    nxt_s.status = bus_rdata[7:0];
                    nxt_s.rdata = bus_rdata;
                    if (bus_rdata[`FL_SR_READY] || s_ff.pcnt == POLL_MAX - 1) begin
                        // ready or poll limit reached: error bits valid only if ready; device stays in status mode
                        nxt_s.supply = 1'b0;
                        nxt_s.wp = 1'b0;
                        nxt_s.timeout = ~bus_rdata[`FL_SR_READY];
                        nxt_s.done = 1'b1;
                        nxt_s.st = FLCSE_ST_IDLE;
                    end else begin
                        // each poll is a fresh read cycle so the status refreshes
                        nxt_s.start = 1'b1;
                        nxt_s.pcnt = s_ff.pcnt + 32'h1;
                    end
                end
            end
            FLCSE_ST_RD: begin
                if (bus_done) begin
                    nxt_s.rdata = bus_rdata;
                    if (s_ff.op == FLCSE_OP_STATUS) begin
                        nxt_s.status = bus_rdata[7:0];
                    end
                    nxt_s.done = 1'b1;
                    nxt_s.st = FLCSE_ST_IDLE;
                end
            end
            FLCSE_ST_RST: begin
                nxt_s.rcnt = s_ff.rcnt - 4'h1;
                if (s_ff.rcnt == 4'h1) begin
                    nxt_s.rp_n = 1'b1;
                    nxt_s.mode = FLCSE_MD_ARRAY;
                    nxt_s.status = `FL_SR_RESET;
                    nxt_s.supply = 1'b0;
                    nxt_s.wp = 1'b0;
                    nxt_s.done = 1'b1;
                    nxt_s.st = FLCSE_ST_IDLE;
                end
            end
            default: begin
                nxt_s.st = FLCSE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_ff <= '{st: FLCSE_ST_IDLE, op: FLCSE_OP_READ, mode: FLCSE_MD_ARRAY,
                      addr: 20'h00000, data: 16'h0000, status: `FL_SR_RESET,
                      pcnt: 32'h00000000, rcnt: 4'h0, rp_n: 1'b1, supply: 1'b0,
                      wp: 1'b0, start: 1'b0, bwrite: 1'b0, baddr: 20'h00000,
                      bdata: 16'h0000, done: 1'b0, refused: 1'b0, timeout: 1'b0,
                      rdata: 16'h0000};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy_out = (s_ff.st != FLCSE_ST_IDLE);
    assign done_out = s_ff.done;
    assign refused_out = s_ff.refused;
    assign timeout_out = s_ff.timeout;
    assign rdata_out = s_ff.rdata;
    assign status_out = s_ff.status;
    assign rp_n_out = s_ff.rp_n;
    assign supply_out = s_ff.supply;
    assign wp_out = s_ff.wp;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    chk_reset_pulse_len: assert property ($fell(rp_n_out) |-> (!rp_n_out)[*8])
        else $error("reset pin pulse too short");
    chk_vpp_refuse: assert property ((req_in && !busy_out && status_out[3] &&
        (op_in == FLCSE_OP_WRITE || op_in == FLCSE_OP_ERASE)) |=> (done_out && refused_out && !busy_out))
        else $error("write or erase started with voltage error set");
    chk_write_setup_code: assert property ((s_ff.st == FLCSE_ST_CMD && s_ff.op == FLCSE_OP_WRITE &&
        !pins_out.we_n) |-> (pins_out.dq[7:0] == 8'h40 && supply_out))
        else $error("write setup code wrong");
    chk_erase_confirm: assert property ((s_ff.st == FLCSE_ST_DATA && s_ff.op == FLCSE_OP_ERASE &&
        !pins_out.we_n) |-> (pins_out.dq[7:0] == 8'hD0 && pins_out.addr == s_ff.addr && supply_out))
        else $error("erase confirm cycle wrong");
    chk_null_write_data: assert property ((s_ff.st == FLCSE_ST_DATA && s_ff.op == FLCSE_OP_NULLW &&
        !pins_out.we_n) |-> (pins_out.dq == 16'hFFFF))
        else $error("null write data not all ones");
    chk_poll_toggle: assert property ((s_ff.st == FLCSE_ST_POLL && bus_done &&
        !bus_rdata[7] && s_ff.pcnt != POLL_MAX - 1) |-> ##[1:3] !pins_out.oe_n)
        else $error("status poll did not toggle output enable");
    chk_ready_ends_op: assert property ((s_ff.st == FLCSE_ST_POLL && bus_done && bus_rdata[7])
        |=> (done_out && !supply_out && status_out[7] && s_ff.mode == FLCSE_MD_STATUS))
        else $error("ready status did not end the operation");
    chk_array_before_read: assert property ((s_ff.st == FLCSE_ST_RD && s_ff.op == FLCSE_OP_READ &&
        !pins_out.oe_n) |-> (s_ff.mode == FLCSE_MD_ARRAY))
        else $error("array read without array mode");
    chk_clear_errors: assert property ((s_ff.st == FLCSE_ST_CMD && s_ff.op == FLCSE_OP_CLEAR && bus_done)
        |=> (status_out[5:3] == 3'h0 && done_out))
        else $error("clear did not drop error flags");

    cov_write_done: cover property (s_ff.op == FLCSE_OP_WRITE && s_ff.st == FLCSE_ST_POLL ##1 done_out);
    cov_erase_suspend: cover property (s_ff.op == FLCSE_OP_SUSPEND && done_out);
    cov_vpp_refused: cover property (refused_out);
    cov_ident_read: cover property (s_ff.op == FLCSE_OP_IDENT && done_out);

endmodule : flcse_host
`default_nettype wire

// *** flcse_flash_model.sv ***
// behavioural boot-block flash: command decode, status register, sparse array
// assumes the controller clock for busy timing; strobe edges are seen at that clock
`timescale 1ns/100ps
`default_nettype none

module flcse_flash_model
    import flcse_pkg::*;
#(
    parameter int BUSY_CYC = 30,
    parameter logic [7:0] BOOT_BLK = 8'h00,
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'hC3 // arbitrary value
) (
    input wire logic clock_in,
    input wire flcse_pins_t pins_in,
    input wire logic rp_n_in,
    input wire logic supply_in,
    input wire logic wp_in,
    input wire logic fail_in,
    output logic [15:0] dq_out
);
    logic [15:0] mem [logic [19:0]];
    logic [1:0] mode = 2'h0;
    logic [6:3] sr = 4'h0;
    logic pend_w = 1'b0, pend_e = 1'b0, erasing = 1'b0, prev_w = 1'b0, prev_r = 1'b0;
    logic [19:0] ta;
    logic [15:0] td, out_q = 16'h0000;
    int busy = 0;
    wire logic wr = ~pins_in.ce_n & ~pins_in.we_n;
    wire logic rd = ~pins_in.ce_n & ~pins_in.oe_n;
    wire logic rdy = (busy == 0) || sr[6];
    // released bus shows the inverse of the last value
    assign dq_out = rd ? out_q : ~out_q;

    always @(posedge clock_in or negedge rp_n_in) begin
        if (!rp_n_in) begin
            sr = 4'h0;
            mode = 2'h0;
            busy = 0;
            {pend_w, pend_e, erasing} = 3'b000;
        end else begin
            if (busy > 0 && !sr[6]) begin
                busy = busy - 1;
                if (busy == 0) begin
                    if (fail_in) sr[erasing ? 5 : 4] = 1'b1;
                    else if (erasing) begin
                        foreach (mem[k]) if (k[19:12] == ta[19:12]) mem[k] = 16'hFFFF;
                    end else mem[ta] = (mem.exists(ta) ? mem[ta] : 16'hFFFF) & td;
                    erasing = 1'b0;
                end
            end
            if (rd && !prev_r) begin
                if ((busy > 0 && !sr[6]) || mode == 2'h2) out_q = {8'h00, rdy, sr, 3'b000};
                else if (mode == 2'h1) out_q = {8'h00, pins_in.addr[0] ? DEVICE_ID : MAKER_ID};
                else out_q = mem.exists(pins_in.addr) ? mem[pins_in.addr] : 16'hFFFF;
            end
            if (!wr && prev_w) begin
                if (busy > 0 && !sr[6]) begin
                    if (erasing && pins_in.dq[7:0] == 8'hB0) sr[6] = 1'b1;
                    if (erasing && pins_in.dq[7:0] == 8'hB0) mode = 2'h2;
                end else if (pend_w || pend_e) begin
                    mode = 2'h2;
                    ta = pins_in.addr;
                    td = pins_in.dq;
                    if (pend_e && pins_in.dq[7:0] != 8'hD0) sr[5:4] = 2'b11;
                    else if (sr[3] || (pend_w && pins_in.dq == 16'hFFFF)) busy = 0;
                    else if (!supply_in) sr[3] = 1'b1;
                    else if (ta[19:12] == BOOT_BLK && !wp_in) sr[pend_e ? 5 : 4] = 1'b1;
                    else busy = BUSY_CYC;
                    erasing = pend_e && busy > 0;
                    {pend_w, pend_e} = 2'b00;
                end else begin
                    case (pins_in.dq[7:0])
                        8'hFF: mode = 2'h0;
                        8'h90: mode = 2'h1;
                        8'h70: mode = 2'h2;
                        8'h50: sr[5:3] = 3'b000;
                        8'h40, 8'h10: pend_w = 1'b1;
                        8'h20: pend_e = 1'b1;
                        8'hD0: sr[6] = 1'b0;
                        default: ;
                    endcase
                end
            end
            prev_w = wr;
            prev_r = rd;
        end
    end
endmodule : flcse_flash_model

`default_nettype wire

// *** tb.sv ***
// self-checking bench: host controller against the flash model
// assumes flcse_host and flcse_flash_model are compiled first
`timescale 1ns/100ps
`default_nettype none

module tb;
    import flcse_pkg::*;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic req_in = 1'b0;
    flcse_op_t op_in = FLCSE_OP_READ;
    logic [19:0] addr_in = 20'h00000;
    logic [15:0] data_in = 16'h0000;
    logic boot_in = 1'b0;
    logic fail = 1'b0;
    logic vpp_ok = 1'b1;
    logic busy_out, done_out, refused_out, timeout_out, rp_n_out, supply_out, wp_out, refd;
    logic [15:0] rdata_out, dq_in;
    logic [7:0] status_out;
    flcse_pins_t pins_out;
    int num_errors = 0;
    int total_checks = 0;

    always #5 clock_in = ~clock_in;

    flcse_host #(.POLL_MAX(20)) flcse_host_i (.clock_in(clock_in), .arst_n_in(arst_n_in), .req_in(req_in),
        .op_in(op_in), .addr_in(addr_in), .data_in(data_in), .boot_in(boot_in), .busy_out(busy_out),
        .done_out(done_out), .refused_out(refused_out), .timeout_out(timeout_out), .rdata_out(rdata_out),
        .status_out(status_out), .dq_in(dq_in), .pins_out(pins_out), .rp_n_out(rp_n_out),
        .supply_out(supply_out), .wp_out(wp_out));
    flcse_flash_model flcse_flash_model_i (.clock_in(clock_in), .pins_in(pins_out), .rp_n_in(rp_n_out),
        .supply_in(supply_out & vpp_ok), .wp_in(wp_out), .fail_in(fail), .dq_out(dq_in));

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: flag %h expected %h", $time, got, exp);
        end
    endtask : check_flag

    task automatic do_op(input flcse_op_t op, input logic [19:0] a, input logic [15:0] d);
        int n;
        logic exp_busy;
        n = 0;
        // refused when the op code is unknown or a write/erase meets a known voltage error
        exp_busy = (op <= FLCSE_OP_RESET) && !(status_out[3] && op inside {FLCSE_OP_WRITE, FLCSE_OP_ERASE});
        @(posedge clock_in);
        req_in <= 1'b1;
        op_in <= op;
        addr_in <= a;
        data_in <= d;
        @(posedge clock_in);
        req_in <= 1'b0;
        #1 check_flag(busy_out, exp_busy);
        while (done_out !== 1'b1 && n < 3000) begin
            @(posedge clock_in);
            #1 n++;
        end
        if (n >= 3000) num_errors++;
        refd = refused_out;
        check_flag(refd, !exp_busy);
        check_flag(timeout_out, 1'b0);
    endtask : do_op

    task automatic t_after_reset();
        check_val({8'h00, status_out}, 16'h0000);
        check_flag(pins_out.ce_n, 1'b1);
        do_op(FLCSE_OP_READ, 20'h12340, 16'h0000);
        check_val(rdata_out, 16'hFFFF);
    endtask : t_after_reset

    task automatic t_ident();
        do_op(FLCSE_OP_IDENT, 20'h00000, 16'h0000);
        check_val(rdata_out, 16'h005A);
        do_op(FLCSE_OP_IDENT, 20'h00001, 16'h0000);
        check_val(rdata_out, 16'h00C3);
        do_op(FLCSE_OP_STATUS, 20'h00000, 16'h0000);
        check_val(rdata_out, 16'h0080);
    endtask : t_ident

    task automatic t_write();
        do_op(FLCSE_OP_WRITE, 20'h12340, 16'h1234);
        check_flag(refd, 1'b0);
        check_val({8'h00, status_out}, 16'h0080);
        do_op(FLCSE_OP_READ, 20'h12340, 16'h0000);
        check_val(rdata_out, 16'h1234);
        @(posedge clock_in) boot_in <= 1'b1;
        do_op(FLCSE_OP_WRITE, 20'h00040, 16'h00FF);
        check_val({8'h00, status_out}, 16'h0080);
        @(posedge clock_in) boot_in <= 1'b0;
        do_op(FLCSE_OP_NULLW, 20'h12340, 16'h0000);
        do_op(FLCSE_OP_STATUS, 20'h00000, 16'h0000);
        check_val(rdata_out, 16'h0080);
    endtask : t_write

    task automatic t_errors();
        @(posedge clock_in) fail <= 1'b1;
        do_op(FLCSE_OP_WRITE, 20'h12350, 16'h00F0);
        check_val({8'h00, status_out}, 16'h0090);
        do_op(FLCSE_OP_ERASE, 20'h12350, 16'h0000);
        check_val({8'h00, status_out}, 16'h00B0);
        @(posedge clock_in) fail <= 1'b0;
        do_op(FLCSE_OP_STATUS, 20'h00000, 16'h0000);
        check_val(rdata_out, 16'h00B0);
        do_op(FLCSE_OP_CLEAR, 20'h00000, 16'h0000);
        do_op(FLCSE_OP_STATUS, 20'h00000, 16'h0000);
        check_val(rdata_out, 16'h0080);
    endtask : t_errors

    task automatic t_vpp();
        @(posedge clock_in) vpp_ok <= 1'b0;
        do_op(FLCSE_OP_WRITE, 20'h12360, 16'h5555);
        check_val({8'h00, status_out}, 16'h0088);
        @(posedge clock_in) vpp_ok <= 1'b1;
        do_op(FLCSE_OP_ERASE, 20'h12360, 16'h0000);
        check_flag(refd, 1'b1);
        do_op(FLCSE_OP_CLEAR, 20'h00000, 16'h0000);
        do_op(FLCSE_OP_ERASE, 20'h12340, 16'h0000);
        check_val({8'h00, status_out}, 16'h0080);
        do_op(FLCSE_OP_SUSPEND, 20'h00000, 16'h0000);
        check_val({8'h00, status_out}, 16'h0080);
        do_op(FLCSE_OP_RESUME, 20'h00000, 16'h0000);
        check_flag(refd, 1'b0);
        do_op(FLCSE_OP_READ, 20'h12340, 16'h0000);
        check_val(rdata_out, 16'hFFFF);
    endtask : t_vpp

    task automatic t_reset_op();
        @(posedge clock_in) fail <= 1'b1;
        do_op(FLCSE_OP_WRITE, 20'h12370, 16'h0F0F);
        @(posedge clock_in) fail <= 1'b0;
        do_op(FLCSE_OP_RESET, 20'h00000, 16'h0000);
        check_val({8'h00, status_out}, 16'h0000);
        do_op(FLCSE_OP_READ, 20'h12370, 16'h0000);
        check_val(rdata_out, 16'hFFFF);
        do_op(FLCSE_OP_STATUS, 20'h00000, 16'h0000);
        check_val(rdata_out, 16'h0080);
        do_op(flcse_op_t'(4'hC), 20'h00000, 16'h0000);
        check_flag(refd, 1'b1);
    endtask : t_reset_op

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (6) @(posedge clock_in);
        arst_n_in <= 1'b1;
        t_after_reset();
        t_ident();
        t_write();
        t_errors();
        t_vpp();
        t_reset_op();
        report_and_stop();
    end

    initial begin
        #300000;
        num_errors++;
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
